//--- dfsc_pkg.sv
// Purpose: shared constants for the dual fractional synthesizer control core
// Assumes: 16-bit serial frames, 4-bit address over 12 data bits
// Notes: register addresses and reset values are local picks
package dfsc_pkg;
    localparam int REG_W = 16;
    localparam int ADDR_LSB = 12;
    localparam int DATA_W = 12;
    localparam int CNT_W = 8;
    localparam int FRAC_W = 18;
    localparam int AUX_FRAC_W = 10;

    localparam logic [3:0] ADR_MAIN_DIV = 4'h0;
    localparam logic [3:0] ADR_MAIN_LSB = 4'h1;
    localparam logic [3:0] ADR_MAIN_MSB = 4'h2;
    localparam logic [3:0] ADR_AUX_DIV = 4'h3;
    localparam logic [3:0] ADR_AUX_DIVD = 4'h4;
    localparam logic [3:0] ADR_REF_DIV = 4'h5;
    localparam logic [3:0] ADR_GAIN = 4'h6;
    localparam logic [3:0] ADR_PWR = 4'h7;
    localparam logic [3:0] ADR_MODE = 4'h8;
    localparam logic [3:0] ADR_MOD = 4'h9;

    // frames shorter than this many edges are modulation samples
    localparam logic [7:0] FRAME_MIN_REG = 8'h0d;

    localparam logic [9:0] N_OFFSET = 10'h020;
    localparam logic [9:0] FRAC_N_MIN = 10'h026;
    localparam logic [9:0] FRAC_N_MAX = 10'h219;
    localparam logic [9:0] INT_N_MIN = 10'h020;
    localparam logic [9:0] INT_N_MAX = 10'h21f;

    localparam int MODE_M18 = 0;
    localparam int MODE_MFRAC = 1;
    localparam int MODE_AFRAC = 2;
    localparam int MODE_LOCKDET = 3;
    localparam int MODE_MUX_LSB = 4;
    localparam int PWR_MAIN = 0;
    localparam int PWR_AUX = 1;
    localparam int PWR_ALL = 2;
    localparam int FIELD_MAIN_LSB = 0;
    localparam int FIELD_AUX_LSB = 5;

    localparam logic [5:0] RST_MODE = 6'h0b;
    localparam logic [4:0] RST_GAIN = 5'h0f;
    localparam logic [8:0] RST_NREG = 9'h006;
    localparam logic [9:0] RST_RATIO = 10'h026;

    typedef enum logic [1:0] {
        DFSC_MUX_LOOP = 2'b00,
        DFSC_MUX_LOCK = 2'b01,
        DFSC_MUX_LOW = 2'b10,
        DFSC_MUX_HIGH = 2'b11
    } dfsc_mux_t;
endpackage : dfsc_pkg

//--- dfsc_link_if.sv
// Purpose: carrier between the serial front end and the control core
// Assumes: word and edge_cnt are read only while chip select is high
// Notes: mux_sel and lock_lvl are quasi-static levels
`timescale 1ns/1ps
`default_nettype none
interface dfsc_link_if;
    logic [15:0] word;
    logic [7:0] edge_cnt;
    logic [1:0] mux_sel;
    logic lock_lvl;
    modport ser (output word, output edge_cnt, input mux_sel, input lock_lvl);
    modport core (input word, input edge_cnt, output mux_sel, output lock_lvl);
endinterface : dfsc_link_if
`default_nettype wire

//--- dfsc_serial.sv
// Purpose: serial shift register and loopback output on the link clock
// Assumes: ser_clk toggles only while ser_cs_n is low, except during reset
// Notes: edge counter runs free; the core takes differences per frame
`timescale 1ns/1ps
`default_nettype none
module dfsc_serial
    import dfsc_pkg::*;
(
    input wire logic ser_clk, // link clock
    input wire logic rst_n, // core reset, resynchronised here
    input wire logic ser_data, // serial data in
    input wire logic ser_cs_n, // chip select
    output logic mux_out, // loopback / status out
    dfsc_link_if.ser lnk // to core
);
    typedef struct packed {
        logic rs1;
        logic rs2;
        logic [15:0] shift;
        logic [7:0] cnt;
        logic [1:0] sel1;
        logic [1:0] sel2;
        logic lk1;
        logic lk2;
    } dfsc_ser_t;

    dfsc_ser_t s;
    dfsc_ser_t next_s;

    always_comb
    begin
        next_s = s;
        next_s.rs1 = rst_n;
        next_s.rs2 = s.rs1;
        next_s.sel1 = lnk.mux_sel;
        next_s.sel2 = s.sel1;
        next_s.lk1 = lnk.lock_lvl;
        next_s.lk2 = s.lk1;
        // a frame shifts before the reset release has crossed, so no bit is lost
        if (!ser_cs_n)
        begin
            // only the newest sixteen bits survive a long frame
            next_s.shift = {s.shift[14:0], ser_data};
            next_s.cnt = s.cnt + 8'h01;
        end
        else if (!s.rs2)
        begin
            next_s.shift = '0;
            next_s.cnt = '0;
        end
    end

    always_ff @(posedge ser_clk)
        s <= next_s;

    // loopback leaves on the falling edge so the host samples it mid-bit
    always_ff @(negedge ser_clk)
    begin
        unique case (dfsc_mux_t'(s.sel2))
            DFSC_MUX_LOOP: mux_out <= s.shift[0];
            DFSC_MUX_LOCK: mux_out <= s.lk2;
            DFSC_MUX_LOW: mux_out <= 1'b0;
            DFSC_MUX_HIGH: mux_out <= 1'b1;
        endcase
    end

    assign lnk.word = s.shift;
    assign lnk.edge_cnt = s.cnt;

    a_shift_in: assert property (@(posedge ser_clk) disable iff (!s.rs2)
        !ser_cs_n |=> s.shift[0] == $past(ser_data) && s.shift[15:1] == $past(s.shift[14:0]))
        else $error("serial bit not shifted in");
endmodule : dfsc_serial
`default_nettype wire

//--- dfsc_core.sv
// Purpose: control core of a dual fractional-N synthesizer
// Assumes: sys_clk stands in for the crystal; link frames end with cs high
// Notes: analog prescalers, pumps and filter live outside this block
`timescale 1ns/1ps
`default_nettype none
module dfsc_core
    import dfsc_pkg::*;
(
    input wire logic sys_clk, // crystal-rate core clock
    input wire logic rst_n, // synchronous reset
    input wire logic sys_ce, // clock enable
    input wire logic ser_clk, // serial clock
    input wire logic ser_data, // serial data
    input wire logic ser_cs_n, // chip select
    input wire logic main_locked, // lock status from detector
    input wire logic pd_up, // detector says raise frequency
    input wire logic pd_dn, // detector says lower frequency
    output logic mux_out, // loopback out
    output logic lock_steer_out, // pin output value
    output logic lock_steer_oe, // pin drive enable
    output logic internal_steer_en, // internal steering on
    output logic main_ref_pulse, // main reference tick
    output logic aux_ref_pulse, // aux reference tick
    output logic [9:0] main_div_ratio, // main instantaneous ratio
    output logic [9:0] aux_div_ratio, // aux instantaneous ratio
    output logic [4:0] main_detector_gain_code, // main gain step
    output logic [4:0] aux_detector_gain_code, // aux gain step
    output logic [3:0] pwr_down // power-down bits
);
    typedef struct packed {
        logic cs1;
        logic cs2;
        logic cs3;
        logic lk1;
        logic lk2;
        logic up1;
        logic up2;
        logic dn1;
        logic dn2;
        logic [7:0] base_cnt;
        logic [8:0] m_nreg_stg;
        logic [8:0] m_nreg;
        logic [7:0] m_lsb_stg;
        logic [17:0] m_frac_stg;
        logic [17:0] m_frac;
        logic m_pend;
        logic [8:0] a_nreg_stg;
        logic [8:0] a_nreg;
        logic [9:0] a_frac_stg;
        logic [9:0] a_frac;
        logic a_pend;
        logic [9:0] ref_codes;
        logic [9:0] gains;
        logic [3:0] pwr;
        logic [5:0] mode;
        logic [11:0] mod;
        logic [4:0] m_rcnt;
        logic [4:0] a_rcnt;
        logic m_tick;
        logic a_tick;
        logic [17:0] m_acc;
        logic [17:0] a_acc;
        logic [9:0] m_ratio;
        logic [9:0] a_ratio;
        logic ls_out;
        logic ls_oe;
        logic steer_int;
        logic pulse_ph;
    } dfsc_state_t;

    dfsc_state_t s;
    dfsc_state_t next_s;
    dfsc_link_if lnk ();

    function automatic logic [9:0] clamp_n(input logic [10:0] n, input logic frac);
        logic [10:0] lo;
        logic [10:0] hi;
        lo = frac ? {1'b0, FRAC_N_MIN} : {1'b0, INT_N_MIN};
        hi = frac ? {1'b0, FRAC_N_MAX} : {1'b0, INT_N_MAX};
        if (n < lo)
            return lo[9:0];
        if (n > hi)
            return hi[9:0];
        return n[9:0];
    endfunction : clamp_n

    // carry out of the accumulator is the modulator's one-bit output
    function automatic logic [18:0] frac_acc(input logic [17:0] acc, input logic [17:0] inc);
        return {1'b0, acc} + {1'b0, inc};
    endfunction : frac_acc

    function automatic logic [11:0] low_mask(input logic [7:0] n);
        logic [11:0] m;
        for (int i = 0; i < DATA_W; i++)
            m[i] = (8'(i) < n);
        return m;
    endfunction : low_mask

    ////////////////////////////////////////////////////////////////////
    dfsc_serial u_serial (
        .ser_clk(ser_clk),
        .rst_n(rst_n),
        .ser_data(ser_data),
        .ser_cs_n(ser_cs_n),
        .mux_out(mux_out),
        .lnk(lnk.ser)
    );

    assign lnk.mux_sel = s.mode[MODE_MUX_LSB +: 2];
    assign lnk.lock_lvl = s.lk2;

    ////////////////////////////////////////////////////////////////////
    logic rise;
    logic [7:0] diff;
    logic [3:0] addr;
    logic [11:0] data;
    logic [11:0] mod_masked;
    logic m_en;
    logic a_en;
    logic m_hit;
    logic a_hit;
    logic [8:0] m_nreg_use;
    logic [17:0] m_frac_use;
    logic [8:0] a_nreg_use;
    logic [9:0] a_frac_use;
    logic [18:0] m_sum_in;
    logic [18:0] m_sum;
    logic [18:0] a_sum;
    logic [10:0] m_base;
    logic [10:0] a_base;

    always_comb
    begin
        next_s = s;
        next_s.cs1 = ser_cs_n;
        next_s.cs2 = s.cs1;
        next_s.cs3 = s.cs2;
        next_s.lk1 = main_locked;
        next_s.lk2 = s.lk1;
        next_s.up1 = pd_up;
        next_s.up2 = s.up1;
        next_s.dn1 = pd_dn;
        next_s.dn2 = s.dn1;

        // frame content is still because the link clock stops with cs high
        rise = s.cs2 & ~s.cs3;
        diff = 8'(lnk.edge_cnt - s.base_cnt);
        addr = lnk.word[REG_W-1:ADDR_LSB];
        data = lnk.word[DATA_W-1:0];
        mod_masked = data & low_mask(diff);

        // reference dividers; code c gives ratio c+1
        m_en = ~s.pwr[PWR_MAIN] & ~s.pwr[PWR_ALL];
        a_en = ~s.pwr[PWR_AUX] & ~s.pwr[PWR_ALL];
        m_hit = m_en && (s.m_rcnt == 5'h00);
        a_hit = a_en && (s.a_rcnt == 5'h00);
        next_s.m_tick = m_hit;
        next_s.a_tick = a_hit;
        if (m_en)
            next_s.m_rcnt = m_hit ? s.ref_codes[FIELD_MAIN_LSB +: 5] : s.m_rcnt - 5'h01;
        if (a_en)
            next_s.a_rcnt = a_hit ? s.ref_codes[FIELD_AUX_LSB +: 5] : s.a_rcnt - 5'h01;

        // staged settings reach the dividers only on a tick
        m_nreg_use = (m_hit && s.m_pend) ? s.m_nreg_stg : s.m_nreg;
        m_frac_use = (m_hit && s.m_pend) ? s.m_frac_stg : s.m_frac;
        a_nreg_use = (a_hit && s.a_pend) ? s.a_nreg_stg : s.a_nreg;
        a_frac_use = (a_hit && s.a_pend) ? s.a_frac_stg : s.a_frac;

        // signed word plus modulation offset; the sign bit lowers the base by one
        m_sum_in = {m_frac_use[17], m_frac_use} + {{7{s.mod[11]}}, s.mod};
        m_sum = frac_acc(s.m_acc, m_sum_in[17:0]);
        a_sum = frac_acc(s.a_acc, {a_frac_use, 8'h00});
        m_base = {2'b00, m_nreg_use} + {1'b0, N_OFFSET};
        a_base = {2'b00, a_nreg_use} + {1'b0, N_OFFSET};

        if (m_hit)
        begin
            next_s.m_nreg = m_nreg_use;
            next_s.m_frac = m_frac_use;
            next_s.m_pend = 1'b0;
            if (s.mode[MODE_MFRAC])
            begin
                next_s.m_acc = m_sum[17:0];
                next_s.m_ratio = clamp_n(m_base + {10'h000, m_sum[18]} - {10'h000, m_sum_in[18]}, 1'b1);
            end
            else
                next_s.m_ratio = clamp_n(m_base, 1'b0);
        end
        if (a_hit)
        begin
            next_s.a_nreg = a_nreg_use;
            next_s.a_frac = a_frac_use;
            next_s.a_pend = 1'b0;
            if (s.mode[MODE_AFRAC])
            begin
                next_s.a_acc = a_sum[17:0];
                next_s.a_ratio = clamp_n(a_base + {10'h000, a_sum[18]} - {10'h000, a_frac_use[9]}, 1'b1);
            end
            else
                next_s.a_ratio = clamp_n(a_base, 1'b0);
        end

        ////////////////////////////////////////////////////////////////
        // writes come after the commit so a new request is never lost
        if (rise && diff != 8'h00)
        begin
            next_s.base_cnt = lnk.edge_cnt;
            if (diff < FRAME_MIN_REG)
                next_s.mod = mod_masked;
            else
            begin
                unique case (addr)
                    ADR_MAIN_DIV:
                    begin
                        next_s.m_nreg_stg = data[8:0];
                        if (!s.mode[MODE_MFRAC])
                            next_s.m_pend = 1'b1;
                    end
                    ADR_MAIN_LSB: next_s.m_lsb_stg = data[7:0];
                    ADR_MAIN_MSB:
                    begin
                        // 10-bit mode scales the word up to the 18-bit accumulator
                        next_s.m_frac_stg = s.mode[MODE_M18] ? {data[9:0], s.m_lsb_stg} : {data[9:0], 8'h00};
                        next_s.m_pend = 1'b1;
                    end
                    ADR_AUX_DIV:
                    begin
                        next_s.a_nreg_stg = data[8:0];
                        if (!s.mode[MODE_AFRAC])
                            next_s.a_pend = 1'b1;
                    end
                    ADR_AUX_DIVD:
                    begin
                        next_s.a_frac_stg = data[9:0];
                        next_s.a_pend = 1'b1;
                    end
                    ADR_REF_DIV: next_s.ref_codes = data[9:0];
                    ADR_GAIN: next_s.gains = data[9:0];
                    ADR_PWR: next_s.pwr = data[3:0];
                    ADR_MODE: next_s.mode = data[5:0];
                    ADR_MOD: next_s.mod = data;
                    default: next_s.mod = s.mod;
                endcase
            end
        end

        ////////////////////////////////////////////////////////////////
        // lock pulses follow the main tick so they stay visible to a slow host
        if (m_hit)
            next_s.pulse_ph = ~s.pulse_ph;
        if (s.mode[MODE_LOCKDET])
        begin
            next_s.steer_int = 1'b1;
            next_s.ls_out = 1'b0;
            next_s.ls_oe = ~s.lk2 & s.pulse_ph;
        end
        else
        begin
            next_s.steer_int = 1'b0;
            next_s.ls_out = s.up2;
            next_s.ls_oe = s.up2 | s.dn2;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.cs1 <= 1'b1;
            s.cs2 <= 1'b1;
            s.cs3 <= 1'b1;
            s.m_nreg_stg <= RST_NREG;
            s.m_nreg <= RST_NREG;
            s.a_nreg_stg <= RST_NREG;
            s.a_nreg <= RST_NREG;
            s.gains <= {RST_GAIN, RST_GAIN};
            s.mode <= RST_MODE;
            s.m_ratio <= RST_RATIO;
            s.a_ratio <= RST_RATIO;
        end
        else if (sys_ce)
            s <= next_s;
    end

    assign lock_steer_out = s.ls_out;
    assign lock_steer_oe = s.ls_oe;
    assign internal_steer_en = s.steer_int;
    assign main_ref_pulse = s.m_tick;
    assign aux_ref_pulse = s.a_tick;
    assign main_div_ratio = s.m_ratio;
    assign aux_div_ratio = s.a_ratio;
    assign main_detector_gain_code = s.gains[FIELD_MAIN_LSB +: 5];
    assign aux_detector_gain_code = s.gains[FIELD_AUX_LSB +: 5];
    assign pwr_down = s.pwr;

    ////////////////////////////////////////////////////////////////////
    default clocking dfsc_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n || !sys_ce);

    a_ref_div_four: assert property (disable iff (!rst_n || !sys_ce || !m_en)
        s.m_tick && $past(s.ref_codes[4:0]) == 5'h03 |=> (!s.m_tick)[*3] ##1 s.m_tick) else $error("main reference ratio wrong");
    a_aux_ref_one: assert property (disable iff (!rst_n || !sys_ce || !a_en)
        s.a_tick && $past(s.ref_codes[9:5]) == 5'h00 |=> s.a_tick) else $error("aux reference ratio wrong");
    a_int_ratio: assert property (s.m_tick && !$past(s.mode[MODE_MFRAC])
        |-> s.m_ratio == {1'b0, s.m_nreg} + N_OFFSET) else $error("integer ratio mismatch");
    a_frac_range: assert property (s.m_tick && $past(s.mode[MODE_MFRAC])
        |-> s.m_ratio inside {[10'h026:10'h219]}) else $error("fractional ratio out of range");
    a_aux_ten_bit: assert property ($changed(s.a_acc) |-> s.a_acc[7:0] == 8'h00)
        else $error("aux accumulator uses more than ten bits");
    a_commit_tick: assert property ($changed(s.m_frac) || $changed(s.m_nreg) |-> s.m_tick)
        else $error("main setting changed off a tick");
    a_msb_commit: assert property (rise && diff >= FRAME_MIN_REG && addr == ADR_MAIN_MSB
        |=> s.m_pend || s.m_tick) else $error("upper dividend write did not arm commit");
    a_mod_frame: assert property (rise && diff != 8'h00 && diff < FRAME_MIN_REG
        |=> s.mod == $past(mod_masked)) else $error("modulation frame not loaded");
    a_lock_hiz: assert property (s.mode[MODE_LOCKDET] && s.lk2 |=> !s.ls_oe)
        else $error("pin driven while locked");
    a_lock_low: assert property (s.ls_oe && s.steer_int |-> !s.ls_out)
        else $error("lock pulse not low");
    a_steer_drive: assert property (!s.mode[MODE_LOCKDET] && s.up2 |=> s.ls_oe && s.ls_out)
        else $error("steering not driven");

    c_reg_write: cover property (rise && diff >= FRAME_MIN_REG);
    c_mod_frame: cover property (rise && diff != 8'h00 && diff < FRAME_MIN_REG);
    c_frac_commit: cover property (s.m_pend ##[1:40] s.m_tick && !s.m_pend);
    c_lock_pulse: cover property (s.ls_oe && s.steer_int);
endmodule : dfsc_core
`default_nettype wire

//--- dfsc_host_model.sv
// Purpose: host end of the three-wire link for the control core bench
// Assumes: link clock of 12 ns that runs inside frames and in the reset bursts with cs high
// Notes: a deselected data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module dfsc_host_model
(
    output logic ser_clk, // link clock
    output logic ser_data, // serial data
    output logic ser_cs_n // chip select
);
    initial
    begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_cs_n = 1'b1;
    end
    // bursts with cs high, only to clear the link-side reset
    task automatic idle_clocks(input int n);
        repeat (n)
        begin
            #6 ser_clk = 1'b1;
            #6 ser_clk = 1'b0;
        end
    endtask : idle_clocks
    // msb first; the far end keeps only the newest bits
    task automatic send(input logic [19:0] word, input int n);
        ser_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            ser_data = word[i];
            #3 ser_clk = 1'b1;
            #6 ser_clk = 1'b0;
            #3;
        end
        ser_cs_n = 1'b1;
        ser_data = ~ser_data;
    endtask : send
endmodule : dfsc_host_model
`default_nettype wire

//--- dual_fractional_synth_control_tb_top.sv
// Purpose: self-checking bench of the synthesizer control core
// Assumes: ref codes 0 or 3 during ratio checks, so ticks come often
// Notes: random fields from an lfsr seeded at 57
`timescale 1ns/1ps
`default_nettype none
module dual_fractional_synth_control_tb_top;
    import dfsc_pkg::*;
    logic sys_clk, rst_n, sys_ce, main_locked, pd_up, pd_dn, s;
    wire ser_clk, ser_data, ser_cs_n;
    logic mux_out, lock_steer_out, lock_steer_oe, internal_steer_en, main_ref_pulse, aux_ref_pulse;
    logic [9:0] main_div_ratio, aux_div_ratio, prev_ratio, n;
    logic [4:0] main_detector_gain_code, aux_detector_gain_code, a, b;
    logic [3:0] pwr_down;
    logic [7:0] rnd;
    int errors, cmp_count, g;
    dfsc_host_model u_host (.ser_clk(ser_clk), .ser_data(ser_data), .ser_cs_n(ser_cs_n));
    dfsc_core DUT (.sys_clk(sys_clk), .rst_n(rst_n), .sys_ce(sys_ce), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_cs_n(ser_cs_n), .main_locked(main_locked), .pd_up(pd_up), .pd_dn(pd_dn), .mux_out(mux_out),
        .lock_steer_out(lock_steer_out), .lock_steer_oe(lock_steer_oe), .internal_steer_en(internal_steer_en),
        .main_ref_pulse(main_ref_pulse), .aux_ref_pulse(aux_ref_pulse), .main_div_ratio(main_div_ratio),
        .aux_div_ratio(aux_div_ratio), .main_detector_gain_code(main_detector_gain_code),
        .aux_detector_gain_code(aux_detector_gain_code), .pwr_down(pwr_down));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : cyc
    // frame plus settle time for the cs synchroniser
    task automatic wr(input logic [3:0] adr, input logic [11:0] dat);
        u_host.send({4'h0, adr, dat}, 16);
        cyc(8);
    endtask : wr
    // cycles between two ticks, 0 when none come within 80
    task automatic gap(input bit aux, output int q);
        int f;
        f = -1;
        q = 0;
        for (int c = 0; c < 80 && q == 0; c++)
        begin
            cyc(1);
            if ((aux ? aux_ref_pulse : main_ref_pulse) === 1'b1)
            begin
                if (f >= 0)
                    q = c - f;
                f = c;
            end
        end
    endtask : gap
    task automatic finish_test;
        if (errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        finish_test();
    end
    // ratio may only move on a reference tick
    always @(negedge sys_clk)
    begin
        if (rst_n === 1'b1 && main_ref_pulse !== 1'b1 && main_div_ratio !== prev_ratio)
            chk("ratio off tick", prev_ratio, main_div_ratio);
        prev_ratio <= main_div_ratio;
    end
    initial
    begin
        rst_n = 1'b0;
        sys_ce = 1'b1;
        main_locked = 1'b1;
        pd_up = 1'b0;
        pd_dn = 1'b0;
        rnd = 8'h39;
        errors = 0;
        cmp_count = 0;
        fork
            u_host.idle_clocks(8);
            cyc(10);
        join
        chk("reset ratio", 16'h0026, main_div_ratio);
        chk("reset gain", 16'h000f, main_detector_gain_code);
        rst_n = 1'b1;
        cyc(2);
        chk("steer internal", 16'h0001, internal_steer_en);
        for (int k = 0; k < 4; k++)
        begin
            rnd = lfsr(rnd);
            a = (k == 0) ? 5'h00 : rnd[4:0];
            rnd = lfsr(rnd);
            b = (k == 0) ? 5'h1f : rnd[4:0];
            // four junk bits lead an over-long frame
            u_host.send({4'hf, ADR_GAIN, 2'h0, b, a}, 20);
            cyc(8);
            chk("main gain", a, main_detector_gain_code);
            chk("aux gain", b, aux_detector_gain_code);
            a = (k == 1) ? 5'h1f : a;
            b = (k == 1) ? 5'h00 : b;
            wr(ADR_REF_DIV, {2'h0, b, a});
            gap(1'b0, g);
            chk("main ref gap", a + 1, 16'(g));
            gap(1'b1, g);
            chk("aux ref gap", b + 1, 16'(g));
        end
        wr(ADR_REF_DIV, 12'h000);
        wr(ADR_MODE, 12'h008);
        for (int k = 0; k < 3; k++)
        begin
            rnd = lfsr(rnd);
            n = (k == 0) ? 10'h000 : (k == 1) ? 10'h1ff : {2'h0, rnd};
            wr(ADR_MAIN_DIV, {3'h0, n[8:0]});
            wr(ADR_AUX_DIV, {3'h0, n[8:0]});
            chk("main int ratio", n + 32, main_div_ratio);
            chk("aux int ratio", n + 32, aux_div_ratio);
        end
        main_locked = 1'b1;
        cyc(6);
        for (int k = 0; k < 10; k++)
        begin
            chk("oe locked", 16'h0000, lock_steer_oe);
            cyc(1);
        end
        main_locked = 1'b0;
        s = 1'b0;
        cyc(6);
        for (int k = 0; k < 10; k++)
        begin
            s = s | lock_steer_oe;
            chk("lock out", 16'h0000, lock_steer_out);
            cyc(1);
        end
        chk("oe pulses", 16'h0001, s);
        wr(ADR_REF_DIV, 12'h003);
        wr(ADR_MODE, 12'h00f);
        wr(ADR_MAIN_DIV, 12'h064);
        n = main_div_ratio;
        wr(ADR_MAIN_LSB, 12'h000);
        chk("main held", n, main_div_ratio);
        wr(ADR_MAIN_MSB, 12'h000);
        cyc(6);
        chk("main frac ratio", 16'h0084, main_div_ratio);
        wr(ADR_MAIN_DIV, 12'h1f9);
        wr(ADR_MAIN_LSB, 12'h0ff);
        wr(ADR_MAIN_MSB, 12'h1ff);
        for (int k = 0; k < 20; k++)
        begin
            cyc(1);
            chk("frac top", 16'h0219, main_div_ratio);
        end
        wr(ADR_MAIN_DIV, 12'h006);
        wr(ADR_MAIN_LSB, 12'h000);
        wr(ADR_MAIN_MSB, 12'h200);
        for (int k = 0; k < 20; k++)
        begin
            cyc(1);
            chk("frac bottom", 16'h0026, main_div_ratio);
        end
        wr(ADR_MODE, 12'h00e);
        wr(ADR_MAIN_DIV, 12'h014);
        chk("10 bit held", 16'h0026, main_div_ratio);
        wr(ADR_MAIN_MSB, 12'h000);
        cyc(6);
        chk("10 bit ratio", 16'h0034, main_div_ratio);
        wr(ADR_AUX_DIV, 12'h032);
        n = aux_div_ratio;
        cyc(6);
        chk("aux held", n, aux_div_ratio);
        wr(ADR_AUX_DIVD, 12'h000);
        cyc(6);
        chk("aux frac ratio", 16'h0052, aux_div_ratio);
        // clock enable low must freeze the reference divider and ratio
        sys_ce = 1'b0;
        n = {main_div_ratio[8:0], main_ref_pulse};
        for (int k = 0; k < 8; k++)
        begin
            cyc(1);
            chk("ce freeze", n, {main_div_ratio[8:0], main_ref_pulse});
        end
        sys_ce = 1'b1;
        wr(ADR_MODE, 12'h000);
        chk("steer internal", 16'h0000, internal_steer_en);
        for (int k = 3; k >= 0; k--)
        begin
            {pd_up, pd_dn} = k[1:0];
            cyc(5);
            chk("steer pin", {14'h0, pd_up, pd_up | pd_dn}, {lock_steer_out, lock_steer_oe});
        end
        // locked level makes the lock selection distinguishable from the low one
        main_locked = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            wr(ADR_MODE, {6'h0, k[1:0], 4'h0});
            wr(ADR_GAIN, 12'h001);
            chk("mux out", (k == 2) ? 16'h0000 : 16'h0001, mux_out);
        end
        rnd = lfsr(rnd);
        wr(ADR_PWR, {9'h0, rnd[2:0]});
        chk("power bits", rnd[2:0], pwr_down);
        wr(ADR_PWR, 12'h007);
        // short frame must not act as a register write
        u_host.send(20'h0000f, 12);
        cyc(8);
        chk("pwr after sample", 16'h0007, pwr_down);
        gap(1'b0, g);
        chk("main stopped", 16'h0000, 16'(g));
        wr(ADR_PWR, 12'h000);
        finish_test();
    end
endmodule : dual_fractional_synth_control_tb_top
`default_nettype wire
